// File: logic/tfc_defines.svh
// register offsets, reset values and field positions of the tx flow-control
// frame settings bank; word indices, byte address is index * 4
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH

`define TFC_NUM_QUEUES        8
`define TFC_IDX_DEST_LOW      12'h60d
`define TFC_IDX_DEST_HIGH     12'h60e
`define TFC_IDX_SRC_LOW       12'h60f
`define TFC_IDX_SRC_HIGH      12'h610
`define TFC_IDX_QUANTA_BASE   12'h620
`define TFC_IDX_HOLD_BASE     12'h628
`define TFC_IDX_SELECT        12'h640
`define TFC_IDX_REQ_MODE      12'h641
`define TFC_IDX_REQ_BITS      12'h642

`define TFC_RST_DEST_LOW      32'hc2000001
`define TFC_RST_DEST_HIGH     16'h0180
`define TFC_RST_SRC_LOW       32'hcbfc5add
`define TFC_RST_SRC_HIGH      16'he100
`define TFC_RST_QUANTA        16'hffff
`define TFC_RST_HOLD          16'hffff
`define TFC_RST_SELECT        1'h1
`define TFC_RST_REQ_SRC       8'h00
`define TFC_RST_REQ_MODE      1'h0
`define TFC_RST_REQ_BITS      8'h00

`define TFC_MODE_BIT          16
`define TFC_REQ_UPPER_LSB     16

`endif

// File: logic/tfc_pkg.sv
// types shared by the tx flow-control settings bank
// assumes tfc_defines.svh is on the include path
`include "tfc_defines.svh"

package tfc_pkg;

  typedef logic [15:0] tfc_quanta_t;
  typedef logic [`TFC_NUM_QUEUES-1:0] tfc_qmask_t;

  typedef enum logic {
    TFC_FRAME_PAUSE,
    TFC_FRAME_PFC
  } tfc_frame_kind_t;

  typedef struct packed {
    logic [31:0]                 dest_low;
    logic [15:0]                 dest_high;
    logic [31:0]                 src_low;
    logic [15:0]                 src_high;
    tfc_quanta_t [`TFC_NUM_QUEUES-1:0] quanta;
    tfc_quanta_t [`TFC_NUM_QUEUES-1:0] hold;
    logic                        select_pfc;
    tfc_qmask_t                  req_from_reg;
    logic                        two_bit_mode;
    tfc_qmask_t                  req_low;
    tfc_qmask_t                  req_high;
    logic [31:0]                 rdata;
    logic                        ack;
    logic                        err;
  } tfc_state_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } tfc_pin_state_t;

endpackage

// File: logic/tfc_pin_sync.sv
// synchroniser for one asynchronous request pin
// three flops; the output changes once the second and third flops agree
`timescale 1ns/1ns

module tfc_pin_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin and clean level
  input  wire logic pin_i,
  output logic      level_o
);

  tfc_pkg::tfc_pin_state_t st;
  tfc_pkg::tfc_pin_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[1:0], pin_i};
    // first stage feeds only the second
    if (st.sync[1] == st.sync[2]) begin
      next_st.level = st.sync[2];
    end
  end

  // reset level matches the idle pin, so no false request follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;

endmodule

// File: logic/tfc_regs.sv
// tx flow-control frame settings bank with a classic wishbone slave
// assumes byte addressing, 32-bit data, one clock; request pins asynchronous
//
// How it works
// - dest address upper 16 bits live in bits 15:0, reset 0x0180.
// - source address low 32 bits are a full read/write register.
// - source address upper 16 bits in bits 15:0, reset 0xe100.
// - per-queue 16-bit pause quanta at index 0x620 plus n, reset 0xffff.
// - per-queue 16-bit xoff hold quanta at 0x628 plus n, reset 0xffff.
// - select bit zero gives pause frames, one gives pfc; resets to one.
// - the pause or pfc choice affects queue 0 only.
// - in 2-bit mode per-queue bit picks pins (0) or register (1).
// - bit 16 of request mode picks 1-bit (0) or 2-bit (1) mode.
// - dest address low 32 bits at 0x60d, reset 0xc2000001.
// - register request combines low and high bits into a 2-bit command.
`timescale 1ns/1ns
`include "tfc_defines.svh"

module tfc_regs (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // request pins
  input  wire logic        xoff_request_pin_low_i,
  input  wire logic        xoff_request_pin_high_i,
  // settings to the frame generator
  output logic [47:0]      fc_dest_addr_o,
  output logic [47:0]      fc_src_addr_o,
  output logic [`TFC_NUM_QUEUES*16-1:0] pause_quanta_o,
  output logic [`TFC_NUM_QUEUES*16-1:0] xoff_hold_quanta_o,
  output logic [`TFC_NUM_QUEUES-1:0]    queue_pfc_o,
  output logic                          two_bit_mode_o,
  output logic [`TFC_NUM_QUEUES-1:0]    request_low_o,
  output logic [`TFC_NUM_QUEUES-1:0]    request_high_o
);

  localparam int NQ = `TFC_NUM_QUEUES;

  tfc_pkg::tfc_state_t st;
  tfc_pkg::tfc_state_t next_st;

  logic        pin_low;
  logic        pin_high;
  logic        access;
  logic [11:0] idx;
  logic        aligned;
  logic        hit;
  logic [31:0] wmask;
  logic [31:0] rd;
  logic [NQ-1:0] req_low;
  logic [NQ-1:0] req_high;

  tfc_pin_sync u_sync_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (xoff_request_pin_low_i),
    .level_o (pin_low)
  );

  tfc_pin_sync u_sync_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (xoff_request_pin_high_i),
    .level_o (pin_high)
  );

  // one new access per request; ack drops the cycle after it rose
  assign access  = wb_cyc_i && wb_stb_i && !st.ack;
  assign idx     = wb_adr_i[13:2];
  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // address decode and read mux
  always_comb begin
    hit = aligned;
    rd  = 32'h0;
    if (idx == `TFC_IDX_DEST_LOW) begin
      rd = st.dest_low;
    end else if (idx == `TFC_IDX_DEST_HIGH) begin
      rd = {16'h0, st.dest_high};
    end else if (idx == `TFC_IDX_SRC_LOW) begin
      rd = st.src_low;
    end else if (idx == `TFC_IDX_SRC_HIGH) begin
      rd = {16'h0, st.src_high};
    end else if (idx >= `TFC_IDX_QUANTA_BASE &&
                 idx < `TFC_IDX_QUANTA_BASE + 12'(NQ)) begin
      rd = {16'h0, st.quanta[3'(idx - `TFC_IDX_QUANTA_BASE)]};
    end else if (idx >= `TFC_IDX_HOLD_BASE &&
                 idx < `TFC_IDX_HOLD_BASE + 12'(NQ)) begin
      rd = {16'h0, st.hold[3'(idx - `TFC_IDX_HOLD_BASE)]};
    end else if (idx == `TFC_IDX_SELECT) begin
      rd = {31'h0, st.select_pfc};
    end else if (idx == `TFC_IDX_REQ_MODE) begin
      rd = 32'h0;
      rd[NQ-1:0]        = st.req_from_reg;
      rd[`TFC_MODE_BIT] = st.two_bit_mode;
    end else if (idx == `TFC_IDX_REQ_BITS) begin
      rd = 32'h0;
      rd[NQ-1:0] = st.req_low;
      rd[`TFC_REQ_UPPER_LSB +: NQ] = st.req_high;
    end else begin
      hit = 1'b0;
    end
  end

  // next state: writes land only on implemented bits, the rest stay zero
  always_comb begin
    logic [31:0] wv;
    logic [31:0] cur;
    wv  = 32'h0;
    cur = rd;
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.rdata = st.rdata;
    next_st.err   = 1'b0;
    // unmapped or misaligned access answers with err, same timing as ack
    if (access && !hit && !st.err) begin
      next_st.err = 1'b1;
    end
    if (access && hit) begin
      next_st.ack = 1'b1;
      if (wb_we_i) begin
        wv = (cur & ~wmask) | (wb_dat_i & wmask);
        if (idx == `TFC_IDX_DEST_LOW) begin
          next_st.dest_low = wv;
        end else if (idx == `TFC_IDX_DEST_HIGH) begin
          next_st.dest_high = wv[15:0];
        end else if (idx == `TFC_IDX_SRC_LOW) begin
          next_st.src_low = wv;
        end else if (idx == `TFC_IDX_SRC_HIGH) begin
          next_st.src_high = wv[15:0];
        end else if (idx >= `TFC_IDX_QUANTA_BASE &&
                     idx < `TFC_IDX_QUANTA_BASE + 12'(NQ)) begin
          next_st.quanta[3'(idx - `TFC_IDX_QUANTA_BASE)] = wv[15:0];
        end else if (idx >= `TFC_IDX_HOLD_BASE &&
                     idx < `TFC_IDX_HOLD_BASE + 12'(NQ)) begin
          next_st.hold[3'(idx - `TFC_IDX_HOLD_BASE)] = wv[15:0];
        end else if (idx == `TFC_IDX_SELECT) begin
          next_st.select_pfc = wv[0];
        end else if (idx == `TFC_IDX_REQ_MODE) begin
          next_st.req_from_reg = wv[NQ-1:0];
          next_st.two_bit_mode = wv[`TFC_MODE_BIT];
        end else begin
          // request bits may change at any time
          next_st.req_low  = wv[NQ-1:0];
          next_st.req_high = wv[`TFC_REQ_UPPER_LSB +: NQ];
        end
      end else begin
        next_st.rdata = rd;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st              <= '0;
      st.dest_low     <= `TFC_RST_DEST_LOW;
      st.dest_high    <= `TFC_RST_DEST_HIGH;
      st.src_low      <= `TFC_RST_SRC_LOW;
      st.src_high     <= `TFC_RST_SRC_HIGH;
      st.quanta       <= {NQ{`TFC_RST_QUANTA}};
      st.hold         <= {NQ{`TFC_RST_HOLD}};
      st.select_pfc   <= `TFC_RST_SELECT;
      st.req_from_reg <= `TFC_RST_REQ_SRC;
      st.two_bit_mode <= `TFC_RST_REQ_MODE;
      st.req_low      <= `TFC_RST_REQ_BITS;
      st.req_high     <= `TFC_RST_REQ_BITS;
    end else begin
      st <= next_st;
    end
  end

  // request routing; the single pin pair is shared by all pin-driven queues
  // and 1-bit mode uses only the low request line
  genvar q;
  generate
    for (q = 0; q < NQ; q++) begin : g_queue
      always_comb begin
        if (st.two_bit_mode && st.req_from_reg[q]) begin
          req_low[q]  = st.req_low[q];
          req_high[q] = st.req_high[q];
        end else if (st.two_bit_mode) begin
          req_low[q]  = pin_low;
          req_high[q] = pin_high;
        end else begin
          req_low[q]  = st.req_low[q];
          req_high[q] = 1'b0;
        end
      end
      assign pause_quanta_o[q*16 +: 16]     = st.quanta[q];
      assign xoff_hold_quanta_o[q*16 +: 16] = st.hold[q];
      if (q == 0) begin : g_q0
        assign queue_pfc_o[q] = st.select_pfc;
      end else begin : g_qn
        assign queue_pfc_o[q] = 1'b1;
      end
    end
  endgenerate

  assign request_low_o  = req_low;
  assign request_high_o = req_high;
  assign two_bit_mode_o = st.two_bit_mode;
  assign fc_dest_addr_o = {st.dest_high, st.dest_low};
  assign fc_src_addr_o  = {st.src_high, st.src_low};
  assign wb_dat_o       = st.rdata;
  assign wb_ack_o       = st.ack;
  assign wb_err_o       = st.err;

endmodule

// File: bench/tfc_regs_assertions.sv
// concurrent checks on the tx flow-control settings bank ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "tfc_defines.svh"

module tfc_regs_assertions (
  // clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // bus
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_ack_o,
  input wire logic                         wb_err_o,
  // settings
  input wire logic [47:0]                  fc_dest_addr_o,
  input wire logic [47:0]                  fc_src_addr_o,
  input wire logic [`TFC_NUM_QUEUES*16-1:0] pause_quanta_o,
  input wire logic [`TFC_NUM_QUEUES*16-1:0] xoff_hold_quanta_o,
  input wire logic [`TFC_NUM_QUEUES-1:0]   queue_pfc_o,
  input wire logic                         two_bit_mode_o,
  input wire logic [`TFC_NUM_QUEUES-1:0]   request_high_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_dest_rst;
    $fell(rst_i) |-> fc_dest_addr_o == 48'h0180_c200_0001;
  endproperty
  a_dest_rst: assert property (p_dest_rst)
    else $error("dest address not at reset value");
  property p_src_rst;
    $fell(rst_i) |-> fc_src_addr_o == 48'he100_cbfc_5add;
  endproperty
  a_src_rst: assert property (p_src_rst)
    else $error("source address not at reset value");
  property p_quanta_rst;
    $fell(rst_i) |-> pause_quanta_o == {`TFC_NUM_QUEUES{16'hffff}};
  endproperty
  a_quanta_rst: assert property (p_quanta_rst)
    else $error("pause quanta not at reset value");
  property p_hold_rst;
    $fell(rst_i) |-> xoff_hold_quanta_o == {`TFC_NUM_QUEUES{16'hffff}};
  endproperty
  a_hold_rst: assert property (p_hold_rst)
    else $error("hold quanta not at reset value");
  property p_sel_rst;
    $fell(rst_i) |-> queue_pfc_o == 8'hff && !two_bit_mode_o;
  endproperty
  a_sel_rst: assert property (p_sel_rst)
    else $error("select or mode not at reset value");
  property p_q_pfc;
    queue_pfc_o[7:1] == 7'h7f;
  endproperty
  a_q_pfc: assert property (p_q_pfc)
    else $error("select leaked past queue 0");
  property p_one_bit;
    !two_bit_mode_o |-> request_high_o == 8'h00;
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("upper request seen in 1-bit mode");
  property p_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");

  c_err: cover property (wb_err_o);
  c_pause: cover property (!queue_pfc_o[0]);
  c_two_bit: cover property (two_bit_mode_o && request_high_o != 8'h00);
endmodule

// File: bench/tfc_regs_test.sv
// self-checking bench for the tx flow-control settings bank
// assumes classic wishbone, byte address = word index * 4, one clock
`timescale 1ns/1ns
`include "tfc_defines.svh"

module tfc_regs_test;
  logic         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic         pin_lo = 0, pin_hi = 0, ack, err, e, mode;
  logic [13:0]  adr = 0;
  logic [31:0]  wdat = 0, rdat, q;
  logic [47:0]  dst, src;
  logic [127:0] pq, hq;
  logic [7:0]   pfc, rlo, rhi;
  logic [3:0]   sel = 4'hf, lanes = 4'hf;
  int           fails = 0, cmp_count = 0;

  tfc_regs u_tfc_regs (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .xoff_request_pin_low_i(pin_lo), .xoff_request_pin_high_i(pin_hi),
    .fc_dest_addr_o(dst), .fc_src_addr_o(src), .pause_quanta_o(pq),
    .xoff_hold_quanta_o(hq), .queue_pfc_o(pfc), .two_bit_mode_o(mode),
    .request_low_o(rlo), .request_high_o(rhi));

  always #50 clk_i = ~clk_i;

  task bus(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, i, 2'b00, d, lanes};
    // no limit here: a hang is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    {cyc, stb, we} <= 3'h0;
  endtask

  // sampled mid-cycle so registered outputs have settled
  task chk(input logic [127:0] got, input logic [127:0] exp);
    @(negedge clk_i);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask

  task rd(input logic [11:0] i, input logic [31:0] x);
    bus(1'b0, i, 32'h0);
    chk(q, x);
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1000000;
    fails++;
    summarize;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h60d, 32'hc200_0001);
    rd(12'h60e, 32'h0000_0180);
    rd(12'h60f, 32'hcbfc_5add);
    rd(12'h610, 32'h0000_e100);
    for (int n = 0; n < 8; n++) begin
      rd(12'h620 + 12'(n), 32'hffff);
      rd(12'h628 + 12'(n), 32'hffff);
    end
    rd(12'h640, 32'h1);
    rd(12'h641, 32'h0);
    $display("test reset_values done");
    wr(12'h60e, 32'hffff_1234);
    rd(12'h60e, 32'h0000_1234);
    wr(12'h60f, 32'ha5a5_5a5a);
    rd(12'h60f, 32'ha5a5_5a5a);
    wr(12'h610, 32'h5555_4321);
    rd(12'h610, 32'h0000_4321);
    chk(dst, 48'h1234_c200_0001);
    chk(src, 48'h4321_a5a5_5a5a);
    lanes = 4'h1;
    wr(12'h60f, 32'h0000_00ff);
    lanes = 4'hf;
    rd(12'h60f, 32'ha5a5_5aff);
    $display("test addresses done");
    for (int n = 0; n < 8; n++) begin
      wr(12'h620 + 12'(n), {16'hffff, 16'h1000 + 16'(n)});
      wr(12'h628 + 12'(n), {16'hffff, 16'h2000 + 16'(n)});
    end
    for (int n = 0; n < 8; n++) begin
      rd(12'h620 + 12'(n), 32'h1000 + n);
      chk(pq[16*n+:16], 16'h1000 + 16'(n));
      rd(12'h628 + 12'(n), 32'h2000 + n);
      chk(hq[16*n+:16], 16'h2000 + 16'(n));
    end
    $display("test quanta done");
    wr(12'h640, 32'hffff_fffe);
    rd(12'h640, 32'h0);
    chk(pfc, 8'hfe);
    wr(12'h640, 32'h1);
    chk(pfc, 8'hff);
    $display("test select done");
    wr(12'h642, 32'hffa5_ff5a);
    rd(12'h642, 32'h00a5_005a);
    chk({rhi, rlo}, 16'h005a);
    @(posedge clk_i);
    pin_lo <= 1'b1;
    wr(12'h641, 32'hffff_fff0);
    rd(12'h641, 32'h0001_00f0);
    chk(mode, 1'b1);
    chk({rhi, rlo}, 16'ha05f);
    @(posedge clk_i);
    pin_lo <= 1'b0;
    pin_hi <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({rhi, rlo}, 16'haf50);
    $display("test requests done");
    bus(1'b1, 12'h611, 32'hffff_ffff);
    chk(e, 1'b1);
    rd(12'h610, 32'h0000_4321);
    $display("test unmapped done");
    // second reset in mid-run must return the programmed fields to their reset values
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h60f, 32'hcbfc_5add);
    chk(dst, 48'h0180_c200_0001);
    chk(pfc, 8'hff);
    $display("test reset_again done");
    summarize;
  end
endmodule

bind tfc_regs tfc_regs_assertions u_tfc_regs_assertions (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .fc_dest_addr_o,
  .fc_src_addr_o, .pause_quanta_o, .xoff_hold_quanta_o, .queue_pfc_o,
  .two_bit_mode_o, .request_high_o);
